/* bits_boc_and_tx_status.sv */
// transmit status flags, code word transmit/receive and align frame capture
//
// Contract
// - DS1: flag density violations in transmit stream
// - E1: same flag marks each align frame
// - DS1: multiframe flag at SF/ESF boundaries
// - E1: multiframe flag at multiframe boundaries
// - flag transmit clock recovered after activity
// - flag transmit clock lost after inactivity
// - status flags clear by writing one
// - interrupt only for enabled flags
// - code reset on rising control bit only
// - new filter settings apply at reset
// - code clear after selected message bits
// - code validation per filter selection
// - ESF: store validated code, flag detected
// - send code repeatedly or idle pattern
// - flag byte sent first, then code bits with code bit 0 first
// - E1: capture received align frame byte
// - line type bit selects E1 or DS1
// - normal E1 align pattern reads 0011011
`timescale 1ns/1ps
`default_nettype none
module bits_boc_and_tx_status #(
  parameter logic [4:0] CLK_WIN = bits_boc_pkg::TX_CLK_WIN // clock activity window
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // synchronous reset, high
  input wire logic [bits_boc_pkg::ADDR_W-1:0] regAddr, // register address
  input wire logic [bits_boc_pkg::DATA_W-1:0] regWrData, // register write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [bits_boc_pkg::DATA_W-1:0] regRdData, // read data, next cycle
  input wire logic txDataBit, // transmit stream bit
  input wire logic txDataValid, // transmit bit qualifier
  input wire logic txAlignStart, // transmit align frame start
  input wire logic txMultiframeStart, // transmit multiframe boundary
  input wire logic txClockSrc, // transmit clock source level
  input wire logic rxDlBit, // received data link bit
  input wire logic rxDlValid, // received data link qualifier
  input wire logic txDlReq, // framer wants next link bit
  output logic txDlBit, // transmit data link bit
  input wire logic rxAlignStart, // received align frame start
  input wire logic [7:0] rxAlignByte, // first eight bits of align frame
  output logic irq_out // interrupt request, high
);
  import bits_boc_pkg::*;

  typedef struct packed {
    logic [TX_FLAGS_W-1:0] txFlags;
    logic [TX_FLAGS_W-1:0] irqEn;
    logic [1:0] rxFlags;
    logic [1:0] frameMode;
    logic [7:0] rxCtl;
    logic [7:0] txCtl;
    logic [CODE_W-1:0] txCode;
    logic [CODE_W-1:0] rxCode;
    logic [7:0] alignByte;
    logic [7:0] rdData;
    logic [4:0] zeroRun;
    logic [7:0] fillCnt;
    logic [DENS_N_MAX-1:0][7:0] ones;
    logic [191:0] bitHist;
    logic clkPrev;
    logic [4:0] clkIdle;
    logic [4:0] clkAct;
    logic clkLost;
    logic rstPrev;
    logic [2:0] actFilter;
    logic [1:0] actClear;
    logic [MSG_W-1:0] rxSh;
    logic [6:0] bitsSince;
    logic [6:0] lostCnt;
    logic codeActive;
    logic [CODE_HIST-1:0][CODE_W:0] codeHist;
    logic [MSG_W-1:0] txSh;
    logic [3:0] txCnt;
    logic txBit;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic e1Mode;
  logic bocOn;
  logic [7:0] fillNext;
  logic [4:0] zeroNext;
  logic [DENS_N_MAX-1:0][7:0] onesNext;
  logic [DENS_N_MAX-1:0] densViol;
  logic densBad;
  logic [MSG_W-1:0] rxShNext;
  logic [CODE_W-1:0] newCode;
  logic msgMatch;
  logic [CODE_HIST-1:0] codeEq;
  logic [3:0] eqCount;
  logic codeValid;
  logic [6:0] clrThresh;
  logic [MSG_W-1:0] codeMsg;
  logic [MSG_W-1:0] txWord;
  logic clkEdge;
  logic wrStatus;

  // mode decode
  assign e1Mode = s_reg.frameMode[BIT_LINE_TYPE];
  assign bocOn = ~e1Mode & s_reg.frameMode[BIT_ESF_SEL];

  // density windows of 8 x (N+1) bits, one running ones count each
  assign fillNext = (s_reg.fillCnt == DENS_WIN_MAX) ? s_reg.fillCnt
                                                   : s_reg.fillCnt + 8'h01;
  assign zeroNext = txDataBit ? 5'h00
                  : ((s_reg.zeroRun == 5'h1F) ? s_reg.zeroRun : s_reg.zeroRun + 5'h01);
  genvar gi;
  generate
    for (gi = 0; gi < DENS_N_MAX; gi++) begin : g_dens
      localparam int WIN = 8 * (gi + 2);
      assign onesNext[gi] = s_reg.ones[gi] + {7'h00, txDataBit}
                          - {7'h00, s_reg.bitHist[WIN-1]};
      assign densViol[gi] = (fillNext >= 8'(WIN)) && (onesNext[gi] < 8'(gi + 1));
    end
  endgenerate
  assign densBad = (|densViol) | (zeroNext > ZERO_RUN_MAX);

  // received data link: newest bit enters at the top
  assign rxShNext = {rxDlBit, s_reg.rxSh[MSG_W-1:1]};
  assign newCode = rxShNext[14:9];
  assign msgMatch = (s_reg.bitsSince >= MSG_GAP) && (rxShNext[7:0] == MSG_FLAG)
                  && ~rxShNext[8] && ~rxShNext[15];

  // compare the incoming code against the last nine codes
  generate
    for (gi = 0; gi < CODE_HIST; gi++) begin : g_hist
      if (gi == 0) begin : g_new
        assign codeEq[gi] = 1'b1;
      end else begin : g_old
        assign codeEq[gi] = s_reg.codeHist[gi-1][CODE_W]
                          && (s_reg.codeHist[gi-1][CODE_W-1:0] == newCode);
      end
    end
  endgenerate

  // number of matches among the last ten codes
  always_comb begin
    eqCount = 4'h0;
    for (int k = 0; k < CODE_HIST; k++) begin
      eqCount = eqCount + {3'h0, codeEq[k]};
    end
  end

  // validation filter on the settings in force
  always_comb begin
    unique case (s_reg.actFilter)
      FILT_THREE: codeValid = &codeEq[2:0];
      FILT_FIVE: codeValid = &codeEq[4:0];
      FILT_SEVEN: codeValid = &codeEq[6:0];
      FILT_7OF10: codeValid = eqCount >= HIST_NEEDED;
      default: codeValid = 1'b1;
    endcase
  end

  // clear threshold 16, 32, 48 or 64 message bits
  assign clrThresh = 7'({s_reg.actClear, 4'h0}) + CLR_STEP;

  // transmit message: flag byte, zero, six code bits, zero
  assign codeMsg = {1'b0, s_reg.txCode, 1'b0, MSG_FLAG};
  assign txWord = s_reg.txCtl[BIT_SEND_CODE] ? codeMsg : {DL_IDLE, DL_IDLE};

  assign clkEdge = txClockSrc ^ s_reg.clkPrev;
  assign wrStatus = regWr && (regAddr == OFF_TX_STATUS_FLAGS);

  // next state
  always_comb begin
    s_next = s_reg;
    // status flag clears by writing one
    if (wrStatus) begin
      s_next.txFlags = s_reg.txFlags & ~regWrData[TX_FLAGS_W-1:0];
    end
    if (regWr && (regAddr == OFF_RX_CODE_STATUS)) begin
      s_next.rxFlags = s_reg.rxFlags & ~regWrData[1:0];
    end
    // plain register writes
    if (regWr) begin
      unique case (regAddr)
        OFF_TX_IRQ_ENABLE: s_next.irqEn = regWrData[TX_FLAGS_W-1:0];
        OFF_FRAME_MODE: s_next.frameMode = regWrData[1:0];
        OFF_RX_CODE_CONTROL: s_next.rxCtl = regWrData & 8'hBE;
        OFF_TX_CODE_CONTROL: s_next.txCtl = regWrData & 8'h40;
        OFF_TX_CODE_VALUE: s_next.txCode = regWrData[CODE_W-1:0];
        default: s_next.rdData = s_reg.rdData;
      endcase
    end

    // density check and align frame marker share one flag
    if (!e1Mode && txDataValid) begin
      s_next.zeroRun = zeroNext;
      s_next.fillCnt = fillNext;
      s_next.ones = onesNext;
      s_next.bitHist = {s_reg.bitHist[190:0], txDataBit};
      if (densBad) begin
        s_next.txFlags[BIT_DENSITY_ALIGN] = 1'b1;
      end
    end
    if (e1Mode && txAlignStart) begin
      s_next.txFlags[BIT_DENSITY_ALIGN] = 1'b1;
    end
    // multiframe boundary strobe in either mode
    if (txMultiframeStart) begin
      s_next.txFlags[BIT_MULTIFRAME] = 1'b1;
    end

    // transmit clock activity monitor
    s_next.clkPrev = txClockSrc;
    s_next.clkIdle = clkEdge ? 5'h00
                   : ((s_reg.clkIdle == 5'h1F) ? s_reg.clkIdle : s_reg.clkIdle + 5'h01);
    if (s_next.clkIdle >= CLK_WIN) begin
      s_next.clkAct = 5'h00;
    end else if ((clkEdge || s_reg.clkAct != 5'h00) && s_reg.clkAct != 5'h1F) begin
      s_next.clkAct = s_reg.clkAct + 5'h01;
    end
    if (!s_reg.clkLost && s_next.clkIdle >= CLK_WIN) begin
      s_next.clkLost = 1'b1;
      s_next.txFlags[BIT_CLK_LOST] = 1'b1;
    end
    if (s_reg.clkLost && s_next.clkAct >= CLK_WIN) begin
      s_next.clkLost = 1'b0;
      s_next.txFlags[BIT_CLK_RECOVERED] = 1'b1;
    end

    // received code word processing
    s_next.rstPrev = s_reg.rxCtl[BIT_CODE_RESET];
    if (s_reg.rxCtl[BIT_CODE_RESET] && !s_reg.rstPrev) begin
      s_next.actFilter = s_reg.rxCtl[FILT_SEL_LSB+:3];
      s_next.actClear = s_reg.rxCtl[CLR_SEL_LSB+:2];
      s_next.rxSh = '0;
      s_next.bitsSince = 7'h00;
      s_next.lostCnt = 7'h00;
      s_next.codeActive = 1'b0;
      s_next.codeHist = '0;
    end else if (bocOn && rxDlValid) begin
      s_next.rxSh = rxShNext;
      s_next.bitsSince = (s_reg.bitsSince == BITS_SAT) ? BITS_SAT
                                                       : s_reg.bitsSince + 7'h01;
      s_next.lostCnt = (s_reg.lostCnt == BITS_SAT) ? BITS_SAT : s_reg.lostCnt + 7'h01;
      if (msgMatch) begin
        s_next.bitsSince = 7'h00;
        s_next.codeHist = {s_reg.codeHist[CODE_HIST-2:0], {1'b1, newCode}};
        if (s_reg.codeActive && newCode == s_reg.rxCode) begin
          s_next.lostCnt = 7'h00;
        end
        if (codeValid && !(s_reg.codeActive && newCode == s_reg.rxCode)) begin
          s_next.rxCode = newCode;
          s_next.rxFlags[BIT_CODE_DETECTED] = 1'b1;
          s_next.codeActive = 1'b1;
          s_next.lostCnt = 7'h00;
        end
      end
      if (s_reg.codeActive && s_next.codeActive && s_next.lostCnt >= clrThresh) begin
        s_next.codeActive = 1'b0;
        s_next.rxFlags[BIT_CODE_CLEARED] = 1'b1;
      end
    end

    // transmit data link bit stream, first bit in bit 0
    if (txDlReq) begin
      s_next.txCnt = s_reg.txCnt + 4'h1;
      if (s_reg.txCnt == 4'h0) begin
        s_next.txBit = txWord[0];
        s_next.txSh = {1'b0, txWord[MSG_W-1:1]};
      end else begin
        s_next.txBit = s_reg.txSh[0];
        s_next.txSh = {1'b0, s_reg.txSh[MSG_W-1:1]};
      end
    end

    // align frame byte, Si in bit 7 and pattern below
    if (e1Mode && rxAlignStart) begin
      s_next.alignByte = rxAlignByte;
    end

    // read data, valid the cycle after the strobe
    s_next.rdData = RD_UNMAPPED;
    if (regRd) begin
      unique case (regAddr)
        OFF_RX_CODE_STATUS: s_next.rdData = {6'h00, s_reg.rxFlags};
        OFF_TX_STATUS_FLAGS: s_next.rdData = {4'h0, s_reg.txFlags};
        OFF_TX_IRQ_ENABLE: s_next.rdData = {4'h0, s_reg.irqEn};
        OFF_FRAME_MODE: s_next.rdData = {6'h00, s_reg.frameMode};
        OFF_RX_CODE_CONTROL: s_next.rdData = s_reg.rxCtl;
        OFF_TX_CODE_CONTROL: s_next.rdData = s_reg.txCtl;
        OFF_RX_CODE_VALUE: s_next.rdData = {2'h0, s_reg.rxCode};
        OFF_TX_CODE_VALUE: s_next.rdData = {2'h0, s_reg.txCode};
        OFF_RX_ALIGN_FRAME_BYTE: s_next.rdData = s_reg.alignByte;
        default: s_next.rdData = RD_UNMAPPED;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs
  assign regRdData = s_reg.rdData;
  assign txDlBit = s_reg.txBit;
  assign irq_out = |(s_reg.txFlags & s_reg.irqEn);

endmodule // bits_boc_and_tx_status
`default_nettype wire

/* bits_boc_pkg.sv */
// constants for the transmit status, code word and align capture block
`default_nettype none
package bits_boc_pkg;
  // register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [7:0] OFF_RX_CODE_STATUS = 8'h38;
  localparam logic [7:0] OFF_TX_STATUS_FLAGS = 8'h3A;
  localparam logic [7:0] OFF_TX_IRQ_ENABLE = 8'h3B;
  localparam logic [7:0] OFF_FRAME_MODE = 8'h3C;
  localparam logic [7:0] OFF_RX_CODE_CONTROL = 8'h40;
  localparam logic [7:0] OFF_TX_CODE_CONTROL = 8'h41;
  localparam logic [7:0] OFF_RX_CODE_VALUE = 8'h42;
  localparam logic [7:0] OFF_TX_CODE_VALUE = 8'h43;
  localparam logic [7:0] OFF_RX_ALIGN_FRAME_BYTE = 8'h50;
  // reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // transmit status / enable bit positions
  localparam int BIT_CLK_LOST = 0;
  localparam int BIT_CLK_RECOVERED = 1;
  localparam int BIT_MULTIFRAME = 2;
  localparam int BIT_DENSITY_ALIGN = 3;
  localparam int TX_FLAGS_W = 4;
  // receive code status bit positions
  localparam int BIT_CODE_DETECTED = 0;
  localparam int BIT_CODE_CLEARED = 1;
  // frame mode register fields
  localparam int BIT_LINE_TYPE = 0;
  localparam int BIT_ESF_SEL = 1;
  // code control fields
  localparam int BIT_CODE_RESET = 7;
  localparam int CLR_SEL_LSB = 4;
  localparam int FILT_SEL_LSB = 1;
  localparam int BIT_SEND_CODE = 6;
  localparam int CODE_W = 6;
  // code filter selections
  localparam logic [2:0] FILT_ONE = 3'h0;
  localparam logic [2:0] FILT_THREE = 3'h1;
  localparam logic [2:0] FILT_FIVE = 3'h2;
  localparam logic [2:0] FILT_SEVEN = 3'h3;
  localparam logic [2:0] FILT_7OF10 = 3'h4;
  localparam int CODE_HIST = 10;
  localparam logic [3:0] HIST_NEEDED = 4'h7;
  // code clear step: 16 message bits per selection step
  localparam logic [6:0] CLR_STEP = 7'h10;
  localparam logic [6:0] BITS_SAT = 7'h7F;
  localparam logic [6:0] MSG_GAP = 7'h0F;
  // data link words, first bit in bit 0
  localparam int MSG_W = 16;
  localparam logic [7:0] MSG_FLAG = 8'hFF;
  localparam logic [7:0] DL_IDLE = 8'h7E;
  // pulse density limits
  localparam logic [4:0] ZERO_RUN_MAX = 5'h0F;
  localparam int DENS_N_MAX = 23;
  localparam logic [7:0] DENS_WIN_MAX = 8'hC0;
  // transmit clock activity window, in master clock periods
  localparam logic [4:0] TX_CLK_WIN = 5'h0F;
endpackage
`default_nettype wire

/* bits_boc_props.sv */
// port assertions for the transmit status and code word block
`timescale 1ns/1ps
`default_nettype none
module bits_boc_props #(
  parameter logic [4:0] CLK_WIN = 5'h0F // clock activity window
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // synchronous reset
  input wire logic [7:0] regAddr, // register address
  input wire logic [7:0] regWrData, // write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  input wire logic [7:0] regRdData, // read data
  input wire logic txAlignStart, // align frame start
  input wire logic txMultiframeStart, // multiframe start
  input wire logic txClockSrc, // transmit clock level
  input wire logic rxAlignStart, // received align start
  input wire logic [7:0] rxAlignByte, // received align byte
  input wire logic irq_out // interrupt request
);
  import bits_boc_pkg::*;
  logic [3:0] enReg;
  logic e1Reg;
  logic srcPrev;
  logic [4:0] idleCnt;
  // shadows of enable and mode, idle clock counter
  always_ff @(posedge clk_sys) begin
    srcPrev <= txClockSrc;
    if (reset) begin
      enReg <= 4'h0;
      e1Reg <= 1'b0;
      idleCnt <= 5'h00;
    end else begin
      if (regWr && regAddr == OFF_TX_IRQ_ENABLE) enReg <= regWrData[3:0];
      if (regWr && regAddr == OFF_FRAME_MODE) e1Reg <= regWrData[0];
      if (txClockSrc != srcPrev) idleCnt <= 5'h00;
      else if (idleCnt != 5'h1F) idleCnt <= idleCnt + 5'h01;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_reset_quiet: assert property (disable iff (1'b0) reset |=> !irq_out && regRdData == 8'h00)
    else $error("outputs not quiet after reset");
  a_unmapped_zero: assert property (regRd && regAddr == 8'h44 |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_irq_masked: assert property (enReg == 4'h0 |-> !irq_out)
    else $error("interrupt with all enables off");
  a_lost_irq: assert property (idleCnt == CLK_WIN && enReg[0] && !regWr |-> ##[0:3] irq_out)
    else $error("lost clock gave no interrupt");
  a_mf_irq: assert property (txMultiframeStart && enReg[2] && !regWr |=> irq_out)
    else $error("multiframe gave no interrupt");
  a_align_irq: assert property (txAlignStart && enReg[3] && e1Reg && !regWr |=> irq_out)
    else $error("align frame gave no interrupt");
  a_align_capture: assert property (rxAlignStart && e1Reg ##1 regRd && regAddr == 8'h50
    |=> regRdData == $past(rxAlignByte, 2))
    else $error("align byte not captured");
  a_irq_hold: assert property (irq_out && !(regWr && (regAddr == OFF_TX_STATUS_FLAGS
    || regAddr == OFF_TX_IRQ_ENABLE)) |=> irq_out)
    else $error("interrupt dropped without clear");
  c_lost: cover property (idleCnt == CLK_WIN && enReg[0]);
  c_capture: cover property (rxAlignStart && e1Reg);
  c_mf: cover property (txMultiframeStart && enReg[2]);
endmodule // bits_boc_props
bind bits_boc_and_tx_status bits_boc_props #(.CLK_WIN(CLK_WIN)) bits_boc_props_i (
  .clk_sys(clk_sys), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .txAlignStart(txAlignStart),
  .txMultiframeStart(txMultiframeStart), .txClockSrc(txClockSrc),
  .rxAlignStart(rxAlignStart), .rxAlignByte(rxAlignByte), .irq_out(irq_out)
);
`default_nettype wire

/* bits_boc_far_end.sv */
// far end of the data link: sends code messages, collects transmit words
`timescale 1ns/1ps
`default_nettype none
module bits_boc_far_end (
  input wire logic clk_sys, // system clock
  input wire logic reset, // synchronous reset
  input wire logic txDlBit, // link bit from block
  output logic txDlReq, // link bit request
  output logic rxDlBit, // link bit to block
  output logic rxDlValid, // link bit qualifier
  input wire logic sendGo, // start one message
  input wire logic [5:0] sendCode, // code to send
  output logic busy, // message in flight
  output logic [15:0] linkWord, // last whole word
  output logic [31:0] wordCnt // words collected
);
  logic [15:0] shiftIn;
  logic [15:0] msgReg;
  logic [4:0] rxLeft;
  logic [3:0] bitCnt;
  logic [1:0] phase;
  logic reqSeen;
  // request a bit every four cycles, send one message bit every other cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      {shiftIn, msgReg, rxLeft, bitCnt, phase, reqSeen} <= '0;
      {txDlReq, rxDlBit, rxDlValid, linkWord, wordCnt} <= '0;
    end else begin
      phase <= phase + 2'h1;
      txDlReq <= (phase == 2'h0);
      reqSeen <= txDlReq;
      if (reqSeen) begin
        shiftIn <= {txDlBit, shiftIn[15:1]};
        bitCnt <= bitCnt + 4'h1;
        if (bitCnt == 4'hF) begin
          linkWord <= {txDlBit, shiftIn[15:1]};
          wordCnt <= wordCnt + 32'h1;
        end
      end
      rxDlValid <= 1'b0;
      rxDlBit <= ~rxDlBit; // line never holds a stale bit
      if (sendGo) begin
        msgReg <= {1'b0, sendCode, 1'b0, 8'hFF};
        rxLeft <= 5'h10;
      end else if (rxLeft != 5'h00 && !rxDlValid) begin
        rxDlBit <= msgReg[0];
        msgReg <= msgReg >> 1;
        rxDlValid <= 1'b1;
        rxLeft <= rxLeft - 5'h01;
      end
    end
  end
  assign busy = (rxLeft != 5'h00) || rxDlValid;
endmodule // bits_boc_far_end
`default_nettype wire

/* bits_boc_and_tx_status_tb.sv */
// self-checking bench for the transmit status and code word block
`timescale 1ns/1ps
`default_nettype none
module bits_boc_and_tx_status_tb;
  import bits_boc_pkg::*;
  logic clk_sys = 0, reset = 1, regWr = 0, regRd = 0, txDataBit = 0, txDataValid = 0;
  logic txAlignStart = 0, txMultiframeStart = 0, txClockSrc = 0, rxAlignStart = 0;
  logic clkRun = 0, sendGo = 0, rxDlBit, rxDlValid, txDlReq, txDlBit, irq_out, busy;
  logic [7:0] regAddr = 0, regWrData = 0, regRdData, rxAlignByte = 0;
  logic [5:0] sendCode = 0;
  logic [15:0] linkWord;
  logic [31:0] wordCnt;
  int miscompares = 0, checks = 0, cyc = 0;
  logic [7:0] rstRegs [7] = '{8'h3B, 8'h40, 8'h41, 8'h42, 8'h43, 8'h50, 8'h44};
  logic [7:0] alignBytes [2] = '{8'h1B, 8'h9B};
  bits_boc_and_tx_status #(.CLK_WIN(5'h0F)) bits_boc_and_tx_status_i (
    .clk_sys(clk_sys), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .txDataBit(txDataBit),
    .txDataValid(txDataValid), .txAlignStart(txAlignStart),
    .txMultiframeStart(txMultiframeStart), .txClockSrc(txClockSrc), .rxDlBit(rxDlBit),
    .rxDlValid(rxDlValid), .txDlReq(txDlReq), .txDlBit(txDlBit),
    .rxAlignStart(rxAlignStart), .rxAlignByte(rxAlignByte), .irq_out(irq_out));
  bits_boc_far_end bits_boc_far_end_i (
    .clk_sys(clk_sys), .reset(reset), .txDlBit(txDlBit), .txDlReq(txDlReq),
    .rxDlBit(rxDlBit), .rxDlValid(rxDlValid), .sendGo(sendGo), .sendCode(sendCode),
    .busy(busy), .linkWord(linkWord), .wordCnt(wordCnt));
  // clock, transmit clock source and hang guard
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (clkRun) txClockSrc <= ~txClockSrc;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input int id);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t check %0d got %h expected %h", $time, id, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    tick();
    regWr <= 1'b0;
    tick(); // let an edge pass before the next strobe
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    regRd <= 1'b1;
    regAddr <= a;
    tick();
    regRd <= 1'b0;
    tick(); // read data stand in the cycle after the strobe
    chk({8'h00, regRdData}, {8'h00, exp}, a);
  endtask
  task automatic feed(input logic b);
    txDataValid <= 1'b1;
    txDataBit <= b;
    tick();
    txDataValid <= 1'b0;
    tick();
  endtask
  task automatic msg(input logic [5:0] c, input int n);
    repeat (n) begin
      sendCode <= c;
      sendGo <= 1'b1;
      tick();
      sendGo <= 1'b0;
      tick();
      for (int i = 0; i < 100 && busy; i++) tick();
    end
  endtask
  task automatic words();
    logic [31:0] w;
    w = wordCnt;
    for (int i = 0; i < 600 && wordCnt < w + 32'h2; i++) tick();
  endtask
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    tick(16);
    reset <= 1'b0;
    tick();
    rd(OFF_TX_STATUS_FLAGS, RST_REG);
    foreach (rstRegs[i]) rd(rstRegs[i], RST_REG);
    wr(OFF_FRAME_MODE, 8'h02);
    wr(OFF_TX_IRQ_ENABLE, 8'h0C);
    rd(OFF_TX_IRQ_ENABLE, 8'h0C);
    wr(OFF_TX_CODE_VALUE, 8'h2D);
    rd(OFF_TX_CODE_VALUE, 8'h2D);
    wr(OFF_TX_CODE_CONTROL, 8'hFF);
    rd(OFF_TX_CODE_CONTROL, 8'h40);
    wr(OFF_RX_CODE_VALUE, 8'hFF);
    rd(OFF_RX_CODE_VALUE, 8'h00);
    wr(OFF_TX_IRQ_ENABLE, 8'h00);
    tick(20);
    rd(OFF_TX_STATUS_FLAGS, 8'h01);
    chk({15'h0000, irq_out}, 16'h0000, 1);
    wr(OFF_TX_IRQ_ENABLE, 8'h01);
    chk({15'h0000, irq_out}, 16'h0001, 2);
    wr(OFF_TX_STATUS_FLAGS, 8'h01);
    chk({15'h0000, irq_out}, 16'h0000, 3);
    clkRun <= 1'b1;
    tick(40);
    rd(OFF_TX_STATUS_FLAGS, 8'h02);
    wr(OFF_TX_IRQ_ENABLE, 8'h03);
    chk({15'h0000, irq_out}, 16'h0001, 4);
    wr(OFF_TX_STATUS_FLAGS, 8'h02);
    chk({15'h0000, irq_out}, 16'h0000, 5);
    clkRun <= 1'b0;
    tick(30);
    chk({15'h0000, irq_out}, 16'h0001, 6);
    wr(OFF_TX_STATUS_FLAGS, 8'h01);
    wr(OFF_TX_IRQ_ENABLE, 8'h0C);
    repeat (25) for (int i = 0; i < 8; i++) feed(i == 0);
    rd(OFF_TX_STATUS_FLAGS, 8'h00);
    repeat (16) feed(1'b0);
    rd(OFF_TX_STATUS_FLAGS, 8'h08);
    wr(OFF_TX_STATUS_FLAGS, 8'h08);
    for (int m = 0; m < 2; m++) begin
      wr(OFF_FRAME_MODE, m[7:0]);
      txMultiframeStart <= 1'b1;
      tick();
      txMultiframeStart <= 1'b0;
      tick();
      chk({15'h0000, irq_out}, 16'h0001, 7);
      rd(OFF_TX_STATUS_FLAGS, 8'h04);
      wr(OFF_TX_STATUS_FLAGS, 8'h04);
      txAlignStart <= 1'b1;
      tick();
      txAlignStart <= 1'b0;
      rd(OFF_TX_STATUS_FLAGS, (m == 1) ? 8'h08 : 8'h00);
      wr(OFF_TX_STATUS_FLAGS, 8'h08);
    end
    wr(OFF_FRAME_MODE, 8'h02);
    wr(OFF_TX_CODE_CONTROL, 8'h00);
    words();
    chk(linkWord, {DL_IDLE, DL_IDLE}, 8);
    wr(OFF_TX_CODE_CONTROL, 8'h40);
    words();
    chk(linkWord, {1'b0, 6'h2D, 1'b0, MSG_FLAG}, 9);
    wr(OFF_RX_CODE_CONTROL, 8'h02);
    msg(6'h15, 1);
    rd(OFF_RX_CODE_STATUS, 8'h01);
    rd(OFF_RX_CODE_VALUE, 8'h15);
    wr(OFF_RX_CODE_STATUS, 8'h01);
    wr(OFF_RX_CODE_CONTROL, 8'hB2);
    msg(6'h2A, 2);
    rd(OFF_RX_CODE_STATUS, 8'h00);
    msg(6'h2A, 1);
    rd(OFF_RX_CODE_STATUS, 8'h01);
    rd(OFF_RX_CODE_VALUE, 8'h2A);
    // other codes only: clear after 64 link bits, not at 48
    wr(OFF_RX_CODE_STATUS, 8'h01);
    msg(6'h0C, 1);
    msg(6'h33, 1);
    msg(6'h0C, 1);
    rd(OFF_RX_CODE_STATUS, 8'h00);
    msg(6'h33, 1);
    rd(OFF_RX_CODE_STATUS, 8'h02);
    // seven of ten, not in a row, after a fresh code reset
    wr(OFF_RX_CODE_STATUS, 8'h03);
    wr(OFF_RX_CODE_CONTROL, 8'h08);
    wr(OFF_RX_CODE_CONTROL, 8'h88);
    msg(6'h21, 6);
    msg(6'h12, 1);
    rd(OFF_RX_CODE_STATUS, 8'h00);
    msg(6'h21, 1);
    rd(OFF_RX_CODE_STATUS, 8'h01);
    rd(OFF_RX_CODE_VALUE, 8'h21);
    wr(OFF_FRAME_MODE, 8'h01);
    foreach (alignBytes[i]) begin
      rxAlignByte <= alignBytes[i];
      rxAlignStart <= 1'b1;
      tick();
      rxAlignStart <= 1'b0;
      rd(OFF_RX_ALIGN_FRAME_BYTE, alignBytes[i]);
    end
    wrap_up();
  end
endmodule // bits_boc_and_tx_status_tb
`default_nettype wire
